//--- sld_pkg.sv
// package of register offsets, field layouts and timing for the supply low detector
package sld_pkg;
  // register byte offsets on the bus
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STAT_OFS    = 8'h04;
  localparam logic [7:0]  MASK_OFS    = 8'h08;
  localparam logic [7:0]  GLOBAL_EN_OFS = 8'h0C;
  // control register fields
  localparam int unsigned TRIP_LSB    = 0;
  localparam int unsigned TRIP_W      = 4;
  localparam int unsigned PWR_BIT     = 4;
  localparam int unsigned STABLE_BIT  = 5;
  localparam logic [3:0]  TRIP_RST    = 4'h5;
  localparam logic        PWR_RST     = 1'b0;
  localparam logic [3:0]  TRIP_RSVD   = 4'h0;
  localparam logic [3:0]  TRIP_EXT    = 4'hF;
  // status and mask share one layout
  localparam int unsigned EV_W        = 2;
  localparam int unsigned EV_LOW      = 0;
  localparam int unsigned EV_STABLE   = 1;
  localparam logic [1:0]  EV_RST      = 2'h0;
  localparam int unsigned GLOBAL_EN_BIT = 0;
  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // reference settling time, counted on the system clock
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SETTLE_US   = 50;
  localparam int unsigned SETTLE_CYC  = SETTLE_US * CLK_MHZ;
  localparam int unsigned CNT_W       = 16;
endpackage

//--- sld_sync.sv
// two-flop synchroniser for the analog status levels
`timescale 1ns/1ps
`default_nettype none
module sld_sync
  import sld_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] async_in,
  output var  logic [1:0] sync_out
);

  logic [1:0] stage1;

  // first stage feeds only the second; metastability settles there
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- sld_ctrl.sv
// supply low detector control, flags and bus slave
// Function
// - four-bit trip select in control bits 3..0
// - codes 1..14 internal ranges, zero reserved
// - all-ones code routes external sense pin
// - bit 4 powers detector and enables detection
// - read-only stable flag at bit 5
// - comparator below set point sets low flag
// - no low flag before reference is stable
// - settling delay is a fixed time
// - flagged and enabled low event requests vector
// - detection runs in sleep and wakes device
// - vector after wake only with global enable
// - reset returns control register, detector off
`timescale 1ns/1ps
`default_nettype none
module sld_ctrl
  import sld_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              comparator_below,
  input  wire logic              reference_ready,
  input  wire logic              sleep_active,
  output var  logic              detector_power_enable,
  output var  logic [3:0]        trip_point_select,
  output var  logic              sense_from_external,
  output var  logic              reference_stable_flag,
  output var  logic              low_supply_irq_flag,
  output var  logic              irq,
  output var  logic              irq_vector_req,
  output var  logic              wake_req
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_fire;
  logic              w_fire;
  logic              ar_fire;
  logic              wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_mask;
  logic              wr_glob;
  logic              rd_hit;
  logic [31:0]       rd_val;
  logic [EV_W-1:0]   status;
  logic [EV_W-1:0]   mask;
  logic              global_irq_enable;
  logic [EV_W-1:0]   event_in;
  logic [EV_W-1:0]   status_clr;
  logic [EV_W-1:0]   next_status;
  logic [CNT_W-1:0]  settle_cnt;
  logic              settle_done;
  logic              trip_ok;
  logic              next_stable;
  logic [1:0]        sync_q;
  logic              below_s;
  logic              ready_s;
  logic              low_event;

  localparam logic [CNT_W-1:0] SETTLE_LIM = CNT_W'(SETTLE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // analog levels come from another domain, so two flops first

  sld_sync u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({reference_ready, comparator_below}),
    .sync_out (sync_q)
  );

  assign below_s = sync_q[0];
  assign ready_s = sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // write channel handshake: address and data accepted in either order

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign wr_addr       = aw_held ? aw_addr_q : s_axi_awaddr;
  assign wr_data       = w_held ? w_data_q : s_axi_wdata;
  assign wr_strb       = w_held ? w_strb_q : s_axi_wstrb;
  assign wr_go         = (aw_held || aw_fire) && (w_held || w_fire);

  // write address decode; only byte lane 0 carries register bits
  assign wr_hit  = (wr_addr == CTRL_OFS) || (wr_addr == STAT_OFS)
                || (wr_addr == MASK_OFS) || (wr_addr == GLOBAL_EN_OFS);
  assign wr_ctrl = wr_go && wr_strb[0] && (wr_addr == CTRL_OFS);
  assign wr_stat = wr_go && wr_strb[0] && (wr_addr == STAT_OFS);
  assign wr_mask = wr_go && wr_strb[0] && (wr_addr == MASK_OFS);
  assign wr_glob = wr_go && wr_strb[0] && (wr_addr == GLOBAL_EN_OFS);

  // hold whichever half arrives first until the other comes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
      w_held    <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end
    else
    begin
      aw_held <= aw_fire ? !wr_go : (aw_held && !wr_go);
      w_held  <= w_fire ? !wr_go : (w_held && !wr_go);
      if (aw_fire)
        aw_addr_q <= s_axi_awaddr;
      if (w_fire)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // write response, one cycle after both halves are in
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: decode on the address, answer one cycle later

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_hit = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == STAT_OFS)
               || (s_axi_araddr == MASK_OFS) || (s_axi_araddr == GLOBAL_EN_OFS);
  // bits 7..6 of control are unimplemented and read zero
  assign rd_val =
      (s_axi_araddr == CTRL_OFS) ? {24'h00_0000, 2'b00, reference_stable_flag,
                                    detector_power_enable, trip_point_select} :
      (s_axi_araddr == STAT_OFS) ? {30'h0000_0000, status} :
      (s_axi_araddr == MASK_OFS) ? {30'h0000_0000, mask} :
      (s_axi_araddr == GLOBAL_EN_OFS) ? {31'h0000_0000, global_irq_enable} :
                                   32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; reset leaves the detector powered down

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trip_point_select     <= TRIP_RST;
      detector_power_enable <= PWR_RST;
      sense_from_external   <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      trip_point_select     <= wr_data[TRIP_LSB +: TRIP_W];
      detector_power_enable <= wr_data[PWR_BIT];
      // all ones swaps the divider tap for the external pin
      sense_from_external   <= wr_data[TRIP_LSB +: TRIP_W] == TRIP_EXT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settling qualifier: counts real time, so it does not track code speed

  assign settle_done = settle_cnt == SETTLE_LIM;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      settle_cnt <= '0;
    else if (!detector_power_enable)
      settle_cnt <= '0;
    else if (!settle_done)
      settle_cnt <= settle_cnt + CNT_W'(1);
  end

  // stable only with power, elapsed time and the analog ready level
  assign next_stable = detector_power_enable && settle_done && ready_s;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reference_stable_flag <= 1'b0;
    else
      reference_stable_flag <= next_stable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // events; the reserved code never raises the low flag

  assign trip_ok   = trip_point_select != TRIP_RSVD;
  // the stable gate masks the false trips seen while powering up
  assign low_event = detector_power_enable && reference_stable_flag
                  && trip_ok && below_s;
  assign event_in[EV_LOW]    = low_event;
  assign event_in[EV_STABLE] = next_stable && !reference_stable_flag;

  // write-one-to-clear; an event in the clear cycle still lands
  assign status_clr  = wr_stat ? wr_data[EV_W-1:0] : EV_RST;
  assign next_status = (status & ~status_clr) | event_in;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status <= EV_RST;
    else
      status <= next_status;
  end

  // mask and global enable registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask              <= EV_RST;
      global_irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_mask)
        mask <= wr_data[EV_W-1:0];
      if (wr_glob)
        global_irq_enable <= wr_data[GLOBAL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt, vector request and wake

  assign low_supply_irq_flag = status[EV_LOW];
  assign irq            = |(status & mask);
  // the vector is taken only with the global enable, also after a wake
  assign irq_vector_req = irq && global_irq_enable;
  // the comparator path keeps running in sleep, so the flag wakes the core
  assign wake_req       = sleep_active && status[EV_LOW] && mask[EV_LOW];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  trip_field_a: assert property (
    wr_ctrl |=> trip_point_select == $past(wr_data[3:0]))
    else $error("trip select not stored from write");

  reserved_code_a: assert property (
    (trip_point_select == TRIP_RSVD && !status[EV_LOW] && !wr_ctrl)
      |=> !status[EV_LOW])
    else $error("reserved trip code raised the low flag");

  ext_route_a: assert property (
    wr_ctrl && wr_data[3:0] == 4'hF |=> sense_from_external)
    else $error("external sense not routed for all-ones code");

  power_off_a: assert property (
    !detector_power_enable |=> !reference_stable_flag && settle_cnt == 0)
    else $error("detector active while powered down");

  stable_cause_a: assert property (
    $rose(reference_stable_flag) |-> $past(detector_power_enable) && $past(ready_s))
    else $error("stable flag rose without power or ready level");

  settle_time_a: assert property (
    $rose(reference_stable_flag) |-> settle_cnt == SETTLE_LIM)
    else $error("stable flag before settling time elapsed");

  low_set_a: assert property (
    low_event |=> status[EV_LOW])
    else $error("low event did not set the flag");

  no_early_a: assert property (
    $rose(status[EV_LOW]) |-> $past(reference_stable_flag))
    else $error("low flag set before reference stable");

  vector_req_a: assert property (
    status[EV_LOW] && mask[EV_LOW] && global_irq_enable |-> irq_vector_req)
    else $error("enabled low flag did not request the vector");

  sleep_wake_a: assert property (
    sleep_active && low_event && mask[EV_LOW] ##1 sleep_active |-> wake_req)
    else $error("low event in sleep did not wake");

  wake_vector_a: assert property (
    wake_req && !global_irq_enable |-> !irq_vector_req)
    else $error("vector taken without global enable");

  flag_sticky_a: assert property (
    status[EV_LOW] && !(wr_stat && wr_data[EV_LOW]) |=> status[EV_LOW])
    else $error("low flag dropped without a clear");

  set_wins_a: assert property (
    low_event && wr_stat && wr_data[EV_LOW] |=> status[EV_LOW])
    else $error("clear beat a simultaneous low event");

  bus_answer_a: assert property (
    wr_go |=> s_axi_bvalid ##0 (s_axi_bresp == ($past(wr_hit) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write answer missing or wrong");

  ctrl_write_c: cover property (wr_ctrl && wr_data[PWR_BIT]);
  stable_rise_c: cover property ($rose(reference_stable_flag));
  low_flag_c: cover property ($rose(status[EV_LOW]) && mask[EV_LOW]);
  wake_c: cover property ($rose(wake_req));

endmodule
`default_nettype wire

//--- sld_ctrl_test.sv
// self-checking bench for the supply low detector control block
`timescale 1ns/1ps
`default_nettype none
module sld_ctrl_test
  import sld_pkg::*;
();
  localparam int SC = 20;
  logic              clk     = 1'b0;
  logic              arst_n  = 1'b0;
  logic [ADDR_W-1:0] awaddr  = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [31:0]       wdata   = '0;
  logic [3:0]        wstrb   = '0;
  logic              wvalid  = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready  = 1'b0;
  logic [ADDR_W-1:0] araddr  = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready  = 1'b0;
  logic              below   = 1'b0;
  logic              ref_rdy = 1'b1;
  logic              sleep   = 1'b0;
  logic              pwr;
  logic [3:0]        trip;
  logic              ext;
  logic              stable;
  logic              lowf;
  logic              irq;
  logic              vec;
  logic              wake;
  logic [31:0]       rdat;
  logic [1:0]        rsp;
  int                fails        = 0;
  int                total_checks = 0;
  int                early        = 0;
  int                n;

  // clock at 100 MHz
  always #5 clk = ~clk;

  sld_ctrl #(.SETTLE_CYCLES(SC)) dut_u (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_below(below),
    .reference_ready(ref_rdy), .sleep_active(sleep),
    .detector_power_enable(pwr), .trip_point_select(trip),
    .sense_from_external(ext), .reference_stable_flag(stable),
    .low_supply_irq_flag(lowf), .irq(irq), .irq_vector_req(vec), .wake_req(wake)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a bound that runs out ends the run as a failure
  task automatic tmo();
    fails++;
    print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: ready sampled at the falling edge, valid dropped after the rising
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    int   k;
    ta = 1'b0;
    tw = 1'b0;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge clk);
      if (awvalid && awready) ta = 1'b1;
      if (wvalid && wready) tw = 1'b1;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (++k > 50) tmo();
    end
    bready <= 1'b1;
    ta = 1'b0;
    while (!ta)
    begin
      @(negedge clk);
      ta = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (++k > 100) tmo();
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic t;
    int   k;
    t = 1'b0;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t)
    begin
      @(negedge clk);
      if (arvalid && arready) t = 1'b1;
      @(posedge clk);
      if (t) arvalid <= 1'b0;
      if (++k > 50) tmo();
    end
    t = 1'b0;
    while (!t)
    begin
      @(negedge clk);
      t = rvalid;
      rdat = rdata;
      rsp = rresp;
      @(posedge clk);
      if (++k > 100) tmo();
    end
    rready <= 1'b0;
  endtask

  // counts cycles to the stable flag; a low flag meanwhile is noted
  task automatic wait_stable();
    n = 0;
    early = 0;
    @(negedge clk);
    while (stable !== 1'b1)
    begin
      if (lowf !== 1'b0) early++;
      @(negedge clk);
      if (++n > 200) tmo();
    end
  endtask

  task automatic pulse_below();
    @(posedge clk);
    below <= 1'b1;
    @(posedge clk);
    below <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(CTRL_OFS);
    chk(rdat, 32'h0000_0005);
    rd(STAT_OFS);
    chk(rdat, 32'h0000_0000);
    rd(8'h40);
    chk(rsp, RESP_SLVERR);
    chk(rdat, 32'h0000_0000);
    wr(8'h44, 32'h0000_0001);
    chk(rsp, RESP_SLVERR);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 16; c++)
    begin
      wr(CTRL_OFS, c);
      chk(rsp, RESP_OKAY);
      @(negedge clk);
      chk(trip, c);
      chk(ext, c == 15);
      rd(CTRL_OFS);
      chk(rdat, c);
    end
  endtask

  // bring-up order with the comparator already low; bit 5 written but read-only
  task automatic t_settle();
    wr(CTRL_OFS, 32'h0000_000E);
    @(posedge clk);
    below <= 1'b1;
    wr(CTRL_OFS, 32'h0000_003E);
    rd(CTRL_OFS);
    chk(rdat, 32'h0000_001E);
    chk(pwr, 1'b1);
    wait_stable();
    chk(early, 0);
    chk(n >= SC - 8 && n <= SC + 4, 1'b1);
    repeat (5) @(negedge clk);
    chk(lowf, 1'b1);
    rd(CTRL_OFS);
    chk(rdat, 32'h0000_003E);
    rd(STAT_OFS);
    chk(rdat, 32'h0000_0003);
    // the synchroniser holds the low level two more edges, and set beats clear
    @(posedge clk);
    below <= 1'b0;
    repeat (3) @(posedge clk);
    wr(STAT_OFS, 32'h0000_0003);
    rd(STAT_OFS);
    chk(rdat, 32'h0000_0000);
  endtask

  task automatic t_irq();
    pulse_below();
    chk(lowf, 1'b1);
    chk(irq, 1'b0);
    wr(MASK_OFS, 32'h0000_0001);
    @(negedge clk);
    chk({irq, vec}, 2'b10);
    wr(GLOBAL_EN_OFS, 32'h0000_0001);
    @(negedge clk);
    chk(vec, 1'b1);
    @(posedge clk);
    sleep <= 1'b1;
    @(negedge clk);
    chk(wake, 1'b1);
    wr(STAT_OFS, 32'h0000_0001);
    wr(GLOBAL_EN_OFS, 32'h0000_0000);
    @(negedge clk);
    chk({wake, irq}, 2'b00);
    pulse_below();
    chk({wake, vec}, 2'b10);
    wr(GLOBAL_EN_OFS, 32'h0000_0001);
    @(negedge clk);
    chk(vec, 1'b1);
    @(posedge clk);
    sleep <= 1'b0;
    wr(STAT_OFS, 32'h0000_0003);
  endtask

  // reserved code never flags, even with power and a stable reference
  task automatic t_reserved();
    wr(CTRL_OFS, 32'h0000_0010);
    wait_stable();
    pulse_below();
    chk({trip, lowf}, 5'b0000_0);
    chk(stable, 1'b1);
    // power off drops the stable flag and blocks detection
    wr(CTRL_OFS, 32'h0000_000E);
    pulse_below();
    chk({pwr, stable, lowf}, 3'b000);
  endtask

  // reset in mid-run with the detector powered
  task automatic t_rerst();
    wr(CTRL_OFS, 32'h0000_001E);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk({pwr, stable, trip}, {2'b00, TRIP_RST});
    chk({lowf, irq, vec, wake}, 4'b0000);
    rd(CTRL_OFS);
    chk(rdat, 32'h0000_0005);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_codes();
    t_settle();
    t_irq();
    t_reserved();
    t_rerst();
    print_verdict();
  end
endmodule
`default_nettype wire
